// file: hdl/pwc_pkg.sv
// package: register map, field layout and reset values of the periodic wakeup counter
package pwc_pkg;

  // register indices on the local register port
  localparam logic [1:0] PWC_OFS_STATUS_CONTROL = 2'h0;
  localparam logic [1:0] PWC_OFS_COUNTER_VALUE  = 2'h1;
  localparam logic [1:0] PWC_OFS_COMPARE_MODULO = 2'h2;

  // counter_status_control field positions
  localparam int PWC_BIT_MATCH_FLAG       = 7;
  localparam int PWC_POS_SOURCE_SELECT_HI = 6;
  localparam int PWC_POS_SOURCE_SELECT_LO = 5;
  localparam int PWC_BIT_MATCH_IRQ_ENABLE = 4;
  localparam int PWC_POS_DIVIDER_HI       = 3;
  localparam int PWC_POS_DIVIDER_LO       = 0;

  // source select codes (bit 1 set picks the internal clock)
  localparam logic [1:0] PWC_SRC_LOW_POWER_OSC = 2'h0;
  localparam logic [1:0] PWC_SRC_EXTERNAL      = 2'h1;

  // reset values
  localparam logic       PWC_RST_MATCH_FLAG    = 1'h0;
  localparam logic [1:0] PWC_RST_SOURCE_SELECT = 2'h0;
  localparam logic       PWC_RST_IRQ_ENABLE    = 1'h0;
  localparam logic [3:0] PWC_RST_DIVIDER_SEL   = 4'h0;
  localparam logic [7:0] PWC_RST_COUNTER       = 8'h00;
  localparam logic [7:0] PWC_RST_MODULO        = 8'h00;
  localparam logic [7:0] PWC_READ_UNMAPPED     = 8'h00;

  // prescaler width: holds the largest ratio, 200000
  localparam int PWC_DIV_W = 18;
  localparam logic [PWC_DIV_W-1:0] PWC_RST_DIVIDER = 18'h0_0000;

  // number of source clock inputs, one synchroniser bit each
  localparam int PWC_SRC_COUNT = 3;

endpackage : pwc_pkg

// file: hdl/pwc_periodic_wakeup_counter.sv
// module: periodic wakeup counter with source select, prescaler and 8-bit modulo counter
// Functional notes
// [RULE_01] counter reaching modulo sets the match flag in bit 7
// [RULE_02] writing 1 to the flag clears flag and request; writing 0 does nothing
// [RULE_03] bits 6:5 pick source: 00 low-power osc, 01 external, 1x internal
// [RULE_04] writing a different source select clears prescaler and counter
// [RULE_05] request raised while flag set and enable bit 4 is 1
// [RULE_06] writing a different divider select clears prescaler and counter
// [RULE_07] select bit 5 low: off,8,32,64,128,256,512,1024,1,2,4,10,16,100,500,1000
// [RULE_08] select bit 5 high: off, 2^10..2^16, then 1000 up to 200000
// [RULE_09] reset clears flag, source select, enable and divider select
// [RULE_10] software enables a source clock before selecting it
// [RULE_11] count register reads the live count; writes are ignored
// [RULE_12] counter cleared by reset, modulo write, and changed select fields only
// [RULE_13] on match the counter returns to zero and the flag sets
// [RULE_14] modulo zero sets the flag on every prescaler output tick
// [RULE_15] any modulo write clears prescaler and counter and stores the value
// [RULE_16] reset loads zero into the modulo register
// [RULE_17] counter advances once per prescaler period, wrapping after the modulo value
// [RULE_18] flag sets on the step from the modulo value to zero
// [RULE_19] a match in the clearing cycle keeps the flag set
// [RULE_20] source clock edges are synchronised before they advance anything
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module pwc_periodic_wakeup_counter (
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       low_power_osc_clock,
  input  wire logic       external_ref_clock,
  input  wire logic       internal_ref_clock,
  output logic            match_irq
);

  localparam int DW = pwc_pkg::PWC_DIV_W;
  localparam int NS = pwc_pkg::PWC_SRC_COUNT;

  // divide ratio for a select code; zero means the prescaler is off
  function automatic logic [DW-1:0] pwc_ratio(input logic sel0, input logic [3:0] ps);
    logic [DW-1:0] r;
    r = 18'h0_0000;
    if (!sel0) begin // see [RULE_07]
      case (ps)
        4'h1:    r = 18'h0_0008;
        4'h2:    r = 18'h0_0020;
        4'h3:    r = 18'h0_0040;
        4'h4:    r = 18'h0_0080;
        4'h5:    r = 18'h0_0100;
        4'h6:    r = 18'h0_0200;
        4'h7:    r = 18'h0_0400;
        4'h8:    r = 18'h0_0001;
        4'h9:    r = 18'h0_0002;
        4'ha:    r = 18'h0_0004;
        4'hb:    r = 18'h0_000a;
        4'hc:    r = 18'h0_0010;
        4'hd:    r = 18'h0_0064;
        4'he:    r = 18'h0_01f4;
        4'hf:    r = 18'h0_03e8;
        default: r = 18'h0_0000;
      endcase
    end else begin // see [RULE_08]
      case (ps)
        4'h1:    r = 18'h0_0400;
        4'h2:    r = 18'h0_0800;
        4'h3:    r = 18'h0_1000;
        4'h4:    r = 18'h0_2000;
        4'h5:    r = 18'h0_4000;
        4'h6:    r = 18'h0_8000;
        4'h7:    r = 18'h1_0000;
        4'h8:    r = 18'h0_03e8;
        4'h9:    r = 18'h0_07d0;
        4'ha:    r = 18'h0_1388;
        4'hb:    r = 18'h0_2710;
        4'hc:    r = 18'h0_4e20;
        4'hd:    r = 18'h0_c350;
        4'he:    r = 18'h1_86a0;
        4'hf:    r = 18'h3_0d40;
        default: r = 18'h0_0000;
      endcase
    end
    return r;
  endfunction

  // source clock synchroniser and edge detector
  // sources idle low, so zero reset values give no false edge after reset
  // only the second stage reads the first, which keeps a metastable sample contained
  // the edge detector compares settled levels only, never the first stage
  // limitation: each source must stay below half of core_clk for every edge to be seen
  logic [NS-1:0] sync1_r;
  logic [NS-1:0] sync2_r;
  logic [NS-1:0] prev_r;
  logic [NS-1:0] sync1_nxt;
  logic [NS-1:0] sync2_nxt;
  logic [NS-1:0] prev_nxt;

  always_comb begin
    sync1_nxt = {internal_ref_clock, external_ref_clock, low_power_osc_clock};
    sync2_nxt = sync1_r; // see [RULE_20]
    prev_nxt  = sync2_r;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      prev_r  <= 3'h0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r  <= prev_nxt;
    end
  end

  // control and counting state
  logic          flag_r;
  logic [1:0]    src_sel_r;
  logic          irq_en_r;
  logic [3:0]    div_sel_r;
  logic [7:0]    modulo_r;
  logic [7:0]    count_r;
  logic [DW-1:0] div_cnt_r;
  logic          irq_r;
  logic [7:0]    rdata_r;

  logic          flag_nxt;
  logic [1:0]    src_sel_nxt;
  logic          irq_en_nxt;
  logic [3:0]    div_sel_nxt;
  logic [7:0]    modulo_nxt;
  logic [7:0]    count_nxt;
  logic [DW-1:0] div_cnt_nxt;
  logic          irq_nxt;
  logic [7:0]    rdata_nxt;

  logic          wr_sc;
  logic          wr_mod;
  logic          src_edge;
  logic [DW-1:0] ratio;
  logic          tick;
  logic          match_set;
  logic          restart;
  logic [7:0]    sc_view;

  // bus decode and software-owned fields
  always_comb begin
    wr_sc       = reg_wr && (reg_addr == pwc_pkg::PWC_OFS_STATUS_CONTROL);
    wr_mod      = reg_wr && (reg_addr == pwc_pkg::PWC_OFS_COMPARE_MODULO);
    // writes to counter_value decode to nothing, so the count stays read-only
    src_sel_nxt = src_sel_r;
    irq_en_nxt  = irq_en_r;
    div_sel_nxt = div_sel_r;
    modulo_nxt  = modulo_r;
    restart     = 1'b0;

    if (wr_sc) begin
      src_sel_nxt = reg_wdata[pwc_pkg::PWC_POS_SOURCE_SELECT_HI:pwc_pkg::PWC_POS_SOURCE_SELECT_LO];
      irq_en_nxt  = reg_wdata[pwc_pkg::PWC_BIT_MATCH_IRQ_ENABLE];
      div_sel_nxt = reg_wdata[pwc_pkg::PWC_POS_DIVIDER_HI:pwc_pkg::PWC_POS_DIVIDER_LO];
      // identical rewrites leave the count running
      // 10 and 11 both pick the internal clock, yet still count as a change
      if (src_sel_nxt != src_sel_r) begin // see [RULE_04]
        restart = 1'b1;
      end
      if (div_sel_nxt != div_sel_r) begin // see [RULE_06]
        restart = 1'b1;
      end
    end

    // a modulo write restarts even when the value is unchanged
    if (wr_mod) begin
      modulo_nxt = reg_wdata; // see [RULE_15]
      restart    = 1'b1;
    end
  end

  // the flag is kept out of this group: hardware sets it, software only clears it
  always_ff @(posedge core_clk) begin
    if (srst) begin // see [RULE_09] see [RULE_16]
      src_sel_r <= pwc_pkg::PWC_RST_SOURCE_SELECT;
      irq_en_r  <= pwc_pkg::PWC_RST_IRQ_ENABLE;
      div_sel_r <= pwc_pkg::PWC_RST_DIVIDER_SEL;
      modulo_r  <= pwc_pkg::PWC_RST_MODULO;
    end else begin
      src_sel_r <= src_sel_nxt;
      irq_en_r  <= irq_en_nxt;
      div_sel_r <= div_sel_nxt;
      modulo_r  <= modulo_nxt;
    end
  end

  // source edge, prescaler and counter
  always_comb begin
    // see [RULE_03]
    if (src_sel_r[1]) begin
      src_edge = sync2_r[2] && !prev_r[2];
    end else if (src_sel_r == pwc_pkg::PWC_SRC_EXTERNAL) begin
      src_edge = sync2_r[1] && !prev_r[1];
    end else begin
      src_edge = sync2_r[0] && !prev_r[0];
    end

    // a zero ratio is the off setting: prescaler and counter hold
    ratio = pwc_ratio(src_sel_r[0], div_sel_r);

    // prescaler: one tick per ratio source edges; it counts source edges, not core_clk cycles
    tick        = 1'b0;
    div_cnt_nxt = div_cnt_r;
    if (ratio != 18'h0_0000 && src_edge) begin
      if (div_cnt_r == ratio - 18'h0_0001) begin
        div_cnt_nxt = pwc_pkg::PWC_RST_DIVIDER;
        tick        = 1'b1;
      end else begin
        div_cnt_nxt = div_cnt_r + 18'h0_0001;
      end
    end

    // counter: wrap from modulo to zero, which is the flag event
    count_nxt = count_r;
    match_set = 1'b0;
    if (tick) begin // see [RULE_17]
      if (count_r == modulo_r) begin // see [RULE_14]
        count_nxt = pwc_pkg::PWC_RST_COUNTER; // see [RULE_13]
        match_set = 1'b1; // see [RULE_18]
      end else begin
        count_nxt = count_r + 8'h01;
      end
    end

    // a restart wins over a tick for the count; the match event still reaches the flag
    if (restart) begin // see [RULE_12]
      div_cnt_nxt = pwc_pkg::PWC_RST_DIVIDER;
      count_nxt   = pwc_pkg::PWC_RST_COUNTER;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      count_r   <= pwc_pkg::PWC_RST_COUNTER;
      div_cnt_r <= pwc_pkg::PWC_RST_DIVIDER;
    end else begin
      count_r   <= count_nxt;
      div_cnt_r <= div_cnt_nxt;
    end
  end

  // match flag and request
  always_comb begin
    // the set is applied after the clear so a coincident event survives
    flag_nxt = flag_r;
    if (wr_sc && reg_wdata[pwc_pkg::PWC_BIT_MATCH_FLAG]) begin // see [RULE_02]
      flag_nxt = 1'b0;
    end
    if (match_set) begin // see [RULE_01] see [RULE_19]
      flag_nxt = 1'b1;
    end

    // registered from the next-state flag, so the request rises in step with the flag
    irq_nxt = flag_nxt && irq_en_nxt; // see [RULE_05]
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin // see [RULE_09]
      flag_r <= pwc_pkg::PWC_RST_MATCH_FLAG;
      irq_r  <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      irq_r  <= irq_nxt;
    end
  end

  // read data, valid in the cycle after the strobe only
  // idle cycles and the unmapped index read as zero, so a stray sample is harmless
  always_comb begin
    sc_view   = {flag_r, src_sel_r, irq_en_r, div_sel_r};
    rdata_nxt = pwc_pkg::PWC_READ_UNMAPPED;

    if (reg_rd) begin
      case (reg_addr)
        pwc_pkg::PWC_OFS_STATUS_CONTROL: rdata_nxt = sc_view;
        pwc_pkg::PWC_OFS_COUNTER_VALUE:  rdata_nxt = count_r; // see [RULE_11]
        pwc_pkg::PWC_OFS_COMPARE_MODULO: rdata_nxt = modulo_r;
        default:                         rdata_nxt = pwc_pkg::PWC_READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_r <= pwc_pkg::PWC_READ_UNMAPPED;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // both outputs come straight from flip-flops
  assign reg_rdata = rdata_r;
  assign match_irq = irq_r;

endmodule // pwc_periodic_wakeup_counter

`default_nettype wire

// file: tb/pwc_checker_assertions.sv
// checker: port assertions for the periodic wakeup counter
`timescale 1ns/100ps
`default_nettype none
module pwc_checker (
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       match_irq
);
  logic [7:0] mod_r;
  logic [7:0] mod_nxt;
  logic [6:0] ctl_r;
  logic [6:0] ctl_nxt;
  // shadows of what software wrote; the flag bit is left out, hardware moves it
  always_comb begin
    mod_nxt = (reg_wr && reg_addr == 2'h2) ? reg_wdata : mod_r;
    ctl_nxt = (reg_wr && reg_addr == 2'h0) ? reg_wdata[6:0] : ctl_r;
    if (srst) begin
      mod_nxt = 8'h00;
      ctl_nxt = 7'h00;
    end
  end
  always_ff @(posedge core_clk) begin
    mod_r <= mod_nxt;
    ctl_r <= ctl_nxt;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  sequence s_cnt_rd;
    reg_rd && reg_addr == 2'h1;
  endsequence
  sequence s_off_wr;
    reg_wr && reg_addr == 2'h0 && reg_wdata[3:0] == 4'h0;
  endsequence
  a_irq_reset: assert property ($past(srst) |-> !match_irq)
    else $error("request high after reset");
  a_rd_reset: assert property (reg_rd && $past(srst, 2) |=> reg_rdata == 8'h00)
    else $error("register not zero after reset");
  a_mod_readback: assert property (reg_rd && reg_addr == 2'h2 |=> reg_rdata == mod_r)
    else $error("modulo readback wrong");
  a_ctl_readback: assert property (reg_rd && reg_addr == 2'h0 |=> reg_rdata[6:0] == ctl_r)
    else $error("control readback wrong");
  a_irq_off: assert property (reg_wr && reg_addr == 2'h0 && !reg_wdata[4] |=>
    !match_irq ##1 (!match_irq || $past(reg_wr)))
    else $error("request while disabled");
  a_off_clear: assert property (s_off_wr ##1 !reg_wr ##1 s_cnt_rd |=> reg_rdata == 8'h00)
    else $error("count not cleared");
  a_rdata_idle: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
    else $error("read data outside read slot");
  // a source phase lasts two cycles or more, so two cycles hold one tick at most
  a_count_step: assert property (s_cnt_rd ##2 s_cnt_rd |=>
    reg_rdata == $past(reg_rdata, 2) || reg_rdata == $past(reg_rdata, 2) + 8'h01 || reg_rdata == 8'h00)
    else $error("count jumped");
endmodule // pwc_checker
bind pwc_periodic_wakeup_counter pwc_checker u_chk (
  .core_clk  (core_clk),
  .srst      (srst),
  .reg_addr  (reg_addr),
  .reg_wdata (reg_wdata),
  .reg_wr    (reg_wr),
  .reg_rd    (reg_rd),
  .reg_rdata (reg_rdata),
  .match_irq (match_irq)
);
`default_nettype wire

// file: tb/tb_top.sv
// testbench: register traffic and source pulses around the wakeup counter
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        core_clk = 1'h0;
  logic        srst = 1'h1;
  logic [1:0]  reg_addr = 2'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic        src = 1'h0;
  logic [7:0]  reg_rdata;
  logic        match_irq;
  logic        rd_q = 1'h0;
  logic [7:0]  exp_q[$];
  logic [7:0]  e;
  logic [7:0]  m;
  logic [31:0] seed = 32'h0000_0034;
  int          n_mismatch = 0;
  int          comparisons = 0;
  always #5 core_clk = ~core_clk;
  // one pulse train feeds all three sources, so every select code can count
  pwc_periodic_wakeup_counter dut (
    .core_clk            (core_clk),
    .srst                (srst),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .low_power_osc_clock (src),
    .external_ref_clock  (src),
    .internal_ref_clock  (src),
    .match_irq           (match_irq)
  );
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic chk(string what, logic [7:0] x, logic [7:0] got);
    comparisons++;
    if (got !== x) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, x, got);
    end
  endtask
  always @(posedge core_clk) begin
    if (rd_q) begin
      e = exp_q.pop_front();
      chk("read data", e, reg_rdata);
    end
    rd_q <= reg_rd;
  end
  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(logic [1:0] a, logic [7:0] x);
    @(posedge core_clk);
    exp_q.push_back(x);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
  endtask
  // two cycles high, at least two low: the shortest phases the count-step check allows
  task automatic pulse(int n);
    repeat (n) begin
      @(posedge core_clk);
      src <= 1'h1;
      repeat (2) @(posedge core_clk);
      src <= 1'h0;
      repeat (2) @(posedge core_clk);
    end
  endtask
  task automatic end_of_test();
    repeat (3) @(posedge core_clk);
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    $display("unexpected run time: expected end within 20000 cycles, seen more");
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    srst <= 1'h0;
    for (int a = 0; a < 4; a++) rd(a[1:0], 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 128; i++) begin
      m = rnd();
      wr(2'h2, m);
      rd(2'h2, m);
      wr(2'h0, {1'h0, 7'(i)});
      rd(2'h1, 8'h00);
      rd(2'h0, {1'h0, 7'(i)});
    end
    $display("test register readback done");
    wr(2'h0, 8'h18);
    wr(2'h2, 8'h03);
    for (int k = 1; k <= 3; k++) begin
      pulse(1);
      wr(2'h1, rnd());
      repeat (2) rd(2'h1, 8'(k));
    end
    pulse(1);
    rd(2'h1, 8'h00);
    rd(2'h0, 8'h98);
    chk("request", 8'h01, {7'h00, match_irq});
    wr(2'h0, 8'h18);
    rd(2'h0, 8'h98);
    wr(2'h0, 8'h98);
    rd(2'h0, 8'h18);
    chk("request", 8'h00, {7'h00, match_irq});
    pulse(2);
    wr(2'h0, 8'h18);
    rd(2'h1, 8'h02);
    wr(2'h0, 8'h1a);
    rd(2'h1, 8'h00);
    wr(2'h0, 8'h18);
    pulse(1);
    wr(2'h0, 8'h38);
    rd(2'h1, 8'h00);
    // internal source, divide by 2: three edges give one tick
    wr(2'h0, 8'h49);
    pulse(3);
    rd(2'h1, 8'h01);
    // second table, divide by 1000: one edge short, then the edge that completes it
    wr(2'h0, 8'h68);
    pulse(999);
    rd(2'h1, 8'h00);
    pulse(1);
    rd(2'h1, 8'h01);
    $display("test counting and restart done");
    wr(2'h0, 8'h08);
    wr(2'h2, 8'h00);
    pulse(1);
    rd(2'h0, 8'h88);
    wr(2'h0, 8'h88);
    pulse(1);
    rd(2'h0, 8'h88);
    // the clear lands on the very edge at which the next wrap sets the flag
    fork
      pulse(1);
      begin
        repeat (2) @(posedge core_clk);
        wr(2'h0, 8'h88);
      end
    join
    rd(2'h0, 8'h88);
    srst <= 1'h1;
    repeat (5) @(posedge core_clk);
    srst <= 1'h0;
    rd(2'h0, 8'h00);
    $display("test modulo zero and reset done");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
